// >>> rtl/fpes_sequencer.v
// Program/erase command sequencer of a serial flash: decodes the dual-input
// program, block erase and chip erase commands and drives the array backend.
// Assumes chip select, serial clock and data pins arrive asynchronously and
// are oversampled; the array backend and latch-set logic share core_clk_in.
`timescale 1ns/10ps
`include "fpes_regs.vh"

module fpes_sequencer #(
	parameter SECTORS = 32,
	parameter SEC_W = 5,
	parameter [31:0] PP_CYCLES = `FPES_T_PP_US * `FPES_CYC_PER_US,
	parameter [31:0] BP_CYCLES = `FPES_T_BP_US * `FPES_CYC_PER_US,
	parameter [31:0] BLKE_CYCLES = `FPES_T_BLKE_US * `FPES_CYC_PER_US,
	parameter [31:0] CHPE_CYCLES = `FPES_T_CHPE_US * `FPES_CYC_PER_US
) (
	// Clock, reset and enable.
	input wire core_clk_in,
	input wire rst_in,
	input wire ce_in,
	// Serial pins, all asynchronous to core_clk_in.
	input wire chip_select_n_in,
	input wire serial_clk_in,
	input wire serial_data_in,
	input wire dual_upper_data_pin_in,
	// Latch, protection and error control from the rest of the device.
	input wire write_enable_set_in,
	input wire error_clear_in,
	input wire [SECTORS-1:0] sector_protect_in,
	input wire [SECTORS-1:0] sector_lock_in,
	// Array backend.
	input wire array_fail_in,
	output reg array_write_out,
	output reg [`FPES_ADDR_W-1:0] array_addr_out,
	output reg [7:0] array_data_out,
	output reg erase_req_out,
	output reg [1:0] erase_size_out,
	// Status.
	output reg busy_out,
	output reg write_enable_latch_out,
	output reg program_erase_error_flag_out
);

	// ************************************************************
	// States and command kinds
	// ************************************************************
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_SHIFT = 5'h02;
	localparam [4:0] ST_DRAIN = 5'h04;
	localparam [4:0] ST_PROG = 5'h08;
	localparam [4:0] ST_WAIT = 5'h10;
	localparam [1:0] CMD_NONE = 2'h0;
	localparam [1:0] CMD_PROG = 2'h1;
	localparam [1:0] CMD_BLOCK = 2'h2;
	localparam [1:0] CMD_CHIP = 2'h3;

	reg [4:0] state;
	reg [2:0] cs_sync;
	reg [2:0] clk_sync;
	reg [1:0] si_sync;
	reg [1:0] dual_sync;
	reg [7:0] shreg;
	reg [2:0] bit_cnt;
	reg opcode_done;
	reg [1:0] addr_cnt;
	reg [1:0] cmd;
	reg [1:0] size_code;
	reg [`FPES_ADDR_W-1:0] addr;
	reg [8:0] data_cnt;
	reg overrun;
	reg [7:0] wr_count;
	reg [7:0] page_buf [0:`FPES_PAGE_BYTES-1];
	reg [`FPES_PAGE_BYTES-1:0] page_valid;
	reg [8:0] walk_idx;
	reg [31:0] timer;

	wire sclk_rise;
	wire cs_fall;
	wire cs_rise;
	wire dual_mode;
	reg [7:0] next_shreg;
	reg [2:0] next_bit_cnt;
	wire byte_done;
	wire data_phase;
	wire fifo_wr_valid;
	wire fifo_wr_ready;
	wire fifo_rd_valid;
	wire fifo_rd_ready;
	wire [7:0] fifo_rd_data;
	wire [SEC_W-1:0] sector;
	wire sector_blocked;
	wire any_blocked;
	wire aligned;
	reg [`FPES_ADDR_W-1:0] erase_addr;

	// ************************************************************
	// Pin synchronisers and edge detection
	// ************************************************************

	// Two flops per data pin, three for select and clock; edges are found between the second and third stage only.
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cs_sync <= 3'h7;
			clk_sync <= 3'h0;
			si_sync <= 2'h0;
			dual_sync <= 2'h0;
		end else if (ce_in) begin
			cs_sync <= {cs_sync[1:0], chip_select_n_in};
			clk_sync <= {clk_sync[1:0], serial_clk_in};
			si_sync <= {si_sync[0], serial_data_in};
			dual_sync <= {dual_sync[0], dual_upper_data_pin_in};
		end
	end

	assign sclk_rise = clk_sync[1] & ~clk_sync[2];
	assign cs_fall = ~cs_sync[1] & cs_sync[2];
	assign cs_rise = cs_sync[1] & ~cs_sync[2];

	// ************************************************************
	// Serial byte assembly
	// ************************************************************

	// Data bytes of the program command come two bits per clock.
	assign data_phase = opcode_done & (addr_cnt == `FPES_ADDR_BYTES);
	assign dual_mode = data_phase & (cmd == CMD_PROG);

	// Next shift value; dual mode puts the upper pin ahead of the serial pin.
	always @* begin
		next_shreg = {shreg[6:0], si_sync[1]};
		next_bit_cnt = bit_cnt + 3'h1;
		if (dual_mode) begin
			next_shreg = {shreg[5:0], dual_sync[1], si_sync[1]};
			next_bit_cnt = bit_cnt + 3'h2;
		end
	end

	assign byte_done = (state == ST_SHIFT) & sclk_rise & (next_bit_cnt == 3'h0);
	assign fifo_wr_valid = byte_done & dual_mode;
	assign aligned = (bit_cnt == 3'h0);

	// Opcode, address and data counting while chip select is low.
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			shreg <= 8'h00;
			bit_cnt <= 3'h0;
			opcode_done <= 1'b0;
			addr_cnt <= 2'h0;
			cmd <= CMD_NONE;
			size_code <= `FPES_SIZE_4K;
			addr <= {`FPES_ADDR_W{1'b0}};
			data_cnt <= 9'h000;
			overrun <= 1'b0;
		end else if (ce_in) begin
			if (state == ST_IDLE && cs_fall) begin
				bit_cnt <= 3'h0;
				opcode_done <= 1'b0;
				addr_cnt <= 2'h0;
				cmd <= CMD_NONE;
				data_cnt <= 9'h000;
				overrun <= 1'b0;
			end else if (state == ST_SHIFT && sclk_rise) begin
				shreg <= next_shreg;
				bit_cnt <= next_bit_cnt;
				if (byte_done) begin
					if (!opcode_done) begin
						opcode_done <= 1'b1;
						// Opcode decode of the program and erase family.
						if (next_shreg == `FPES_OP_DUAL_PROG) begin
							cmd <= CMD_PROG;
						end else if (next_shreg == `FPES_OP_ERASE_4K) begin
							cmd <= CMD_BLOCK;
							size_code <= `FPES_SIZE_4K;
						end else if (next_shreg == `FPES_OP_ERASE_32K) begin
							cmd <= CMD_BLOCK;
							size_code <= `FPES_SIZE_32K;
						end else if (next_shreg == `FPES_OP_ERASE_64K) begin
							cmd <= CMD_BLOCK;
							size_code <= `FPES_SIZE_64K;
						end else if (next_shreg == `FPES_OP_CHIP_A ||
							next_shreg == `FPES_OP_CHIP_B) begin
							cmd <= CMD_CHIP;
							size_code <= `FPES_SIZE_CHIP;
						end
					end else if (cmd != CMD_CHIP && addr_cnt != `FPES_ADDR_BYTES) begin
						// Three address bytes; erase input past them is ignored.
						addr <= {addr[`FPES_ADDR_W-9:0], next_shreg};
						addr_cnt <= addr_cnt + 2'h1;
					end else if (cmd == CMD_PROG) begin
						if (data_cnt != 9'h100)
							data_cnt <= data_cnt + 9'h001;
						// The pins cannot be stalled, so a full queue spoils the command.
						if (!fifo_wr_ready)
							overrun <= 1'b1;
					end
				end
			end
		end
	end

	// ************************************************************
	// Data FIFO and page buffer
	// ************************************************************
	assign fifo_rd_ready = (state == ST_SHIFT) | (state == ST_DRAIN);

	fpes_fifo #(
		.WIDTH(8),
		.DEPTH(`FPES_FIFO_DEPTH),
		.AW(2)
	) u_fifo (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.flush_in(cs_fall & (state == ST_IDLE)),
		.wr_valid_in(fifo_wr_valid),
		.wr_ready_out(fifo_wr_ready),
		.wr_data_in(next_shreg),
		.rd_valid_out(fifo_rd_valid),
		.rd_ready_in(fifo_rd_ready),
		.rd_data_out(fifo_rd_data)
	);

	// Bytes land at start offset plus count, modulo the page, so overflow wraps
	// inside the page and later bytes overwrite earlier ones.
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_count <= 8'h00;
			page_valid <= {`FPES_PAGE_BYTES{1'b0}};
		end else if (ce_in) begin
			if (state == ST_IDLE && cs_fall) begin
				wr_count <= 8'h00;
				page_valid <= {`FPES_PAGE_BYTES{1'b0}};
			end else if (fifo_rd_valid && fifo_rd_ready) begin
				wr_count <= wr_count + 8'h01;
				page_valid[addr[7:0] + wr_count] <= 1'b1;
			end
		end
	end

	// Buffer storage; only slots marked valid are ever programmed.
	always @(posedge core_clk_in) begin
		if (ce_in && fifo_rd_valid && fifo_rd_ready)
			page_buf[addr[7:0] + wr_count] <= fifo_rd_data;
	end

	// ************************************************************
	// Protection and erase address
	// ************************************************************
	assign sector = addr[`FPES_SECTOR_LSB +: SEC_W];
	// A 4 or 32 kB block never straddles a sector, so one lookup covers every block size.
	assign sector_blocked = sector_protect_in[sector] | sector_lock_in[sector];
	assign any_blocked = |(sector_protect_in | sector_lock_in);

	// Low address bits are forced to zero per block size.
	always @* begin
		erase_addr = addr;
		if (size_code == `FPES_SIZE_4K)
			erase_addr[`FPES_IGNORE_4K-1:0] = {`FPES_IGNORE_4K{1'b0}};
		else if (size_code == `FPES_SIZE_32K)
			erase_addr[`FPES_IGNORE_32K-1:0] = {`FPES_IGNORE_32K{1'b0}};
		else if (size_code == `FPES_SIZE_64K)
			erase_addr[`FPES_IGNORE_64K-1:0] = {`FPES_IGNORE_64K{1'b0}};
		else
			erase_addr = {`FPES_ADDR_W{1'b0}};
	end

	// ************************************************************
	// Command execution
	// ************************************************************

	// Decides at release, then walks the page or waits out the erase timer.
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= ST_IDLE;
			walk_idx <= 9'h000;
			timer <= 32'h0000_0000;
			busy_out <= 1'b0;
			write_enable_latch_out <= 1'b0;
			program_erase_error_flag_out <= 1'b0;
			array_write_out <= 1'b0;
			array_addr_out <= {`FPES_ADDR_W{1'b0}};
			array_data_out <= 8'hFF;
			erase_req_out <= 1'b0;
			erase_size_out <= `FPES_SIZE_4K;
		end else if (ce_in) begin
			array_write_out <= 1'b0;
			erase_req_out <= 1'b0;
			// Verify failures reported while busy set the flag; set beats clear.
			if (busy_out && array_fail_in)
				program_erase_error_flag_out <= 1'b1;
			else if (error_clear_in)
				program_erase_error_flag_out <= 1'b0;
			if (write_enable_set_in)
				write_enable_latch_out <= 1'b1;
			if (timer != 32'h0000_0000)
				timer <= timer - 32'h0000_0001;
			case (state)
				ST_IDLE: begin
					if (cs_fall)
						state <= ST_SHIFT;
				end
				ST_SHIFT: begin
					if (cs_rise)
						state <= ST_DRAIN;
				end
				ST_DRAIN: begin
					// Wait for queued bytes to reach the page buffer before deciding.
					if (!fifo_rd_valid) begin
						state <= ST_IDLE;
						if (!write_enable_latch_out || cmd == CMD_NONE) begin
							// Latch clear or foreign opcode: nothing happens.
							state <= ST_IDLE;
						end else if (cmd == CMD_PROG) begin
							if (!data_phase || data_cnt == 9'h000 || !aligned ||
								overrun || sector_blocked) begin
								// Abort with nothing written, latch cleared.
								if (!write_enable_set_in)
									write_enable_latch_out <= 1'b0;
							end else begin
								// Latch drops at the start, well before completion.
								if (!write_enable_set_in)
									write_enable_latch_out <= 1'b0;
								busy_out <= 1'b1;
								walk_idx <= 9'h000;
								timer <= (data_cnt == 9'h001) ? BP_CYCLES : PP_CYCLES;
								state <= ST_PROG;
							end
						end else if (!aligned || (cmd == CMD_BLOCK &&
							(!data_phase || sector_blocked)) ||
							(cmd == CMD_CHIP && any_blocked)) begin
							// Erase abort clears the latch.
							if (!write_enable_set_in)
								write_enable_latch_out <= 1'b0;
						end else begin
							// Self-timed erase; busy shown, latch cleared early.
							if (!write_enable_set_in)
								write_enable_latch_out <= 1'b0;
							busy_out <= 1'b1;
							erase_req_out <= 1'b1;
							erase_size_out <= size_code;
							array_addr_out <= erase_addr;
							timer <= (cmd == CMD_CHIP) ? CHPE_CYCLES : BLKE_CYCLES;
							state <= ST_WAIT;
						end
					end
				end
				ST_PROG: begin
					// Only sent bytes are written; the rest of the page stays erased.
					array_write_out <= page_valid[walk_idx[7:0]];
					array_addr_out <= {addr[`FPES_ADDR_W-1:8], walk_idx[7:0]};
					array_data_out <= page_buf[walk_idx[7:0]];
					walk_idx <= walk_idx + 9'h001;
					if (walk_idx == 9'h0FF)
						state <= ST_WAIT;
				end
				ST_WAIT: begin
					// Busy holds until the self-timed duration runs out.
					if (timer == 32'h0000_0000) begin
						busy_out <= 1'b0;
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

// >>> rtl/fpes_regs.vh
// Constants shared by the flash program/erase sequencer and its data FIFO.
// Assumes it is included by bare name; it holds definitions only.
`ifndef FPES_REGS_VH
`define FPES_REGS_VH

// ************************************************************
// Command opcodes
// ************************************************************
`define FPES_OP_DUAL_PROG 8'hA2
`define FPES_OP_ERASE_4K 8'h20
`define FPES_OP_ERASE_32K 8'h52
`define FPES_OP_ERASE_64K 8'hD8
`define FPES_OP_CHIP_A 8'h60
`define FPES_OP_CHIP_B 8'hC7

// ************************************************************
// Erase size codes driven on erase_size_out
// ************************************************************
`define FPES_SIZE_4K 2'h0
`define FPES_SIZE_32K 2'h1
`define FPES_SIZE_64K 2'h2
`define FPES_SIZE_CHIP 2'h3

// ************************************************************
// Address layout
// ************************************************************
`define FPES_ADDR_W 24
`define FPES_IGNORE_4K 12
`define FPES_IGNORE_32K 15
`define FPES_IGNORE_64K 16
`define FPES_SECTOR_LSB 16
`define FPES_PAGE_BYTES 256
`define FPES_ADDR_BYTES 2'h3
`define FPES_FIFO_DEPTH 4

// ************************************************************
// Timing: self-timed durations in microseconds and the clock rate
// ************************************************************
`define FPES_CLK_PERIOD_NS 4
`define FPES_CYC_PER_US (1000 / `FPES_CLK_PERIOD_NS)
`define FPES_T_PP_US 2000
`define FPES_T_BP_US 50
`define FPES_T_BLKE_US 20000
`define FPES_T_CHPE_US 100000

`endif

// >>> rtl/fpes_fifo.v
// Small synchronous FIFO between the serial byte assembler and the page buffer.
// Assumes one clock, an asynchronous active-high reset and a freezing clock enable.
`timescale 1ns/10ps

module fpes_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	// Clock, reset and enable.
	input wire core_clk_in,
	input wire rst_in,
	input wire ce_in,
	input wire flush_in,
	// Filling side.
	input wire wr_valid_in,
	output wire wr_ready_out,
	input wire [WIDTH-1:0] wr_data_in,
	// Draining side.
	output wire rd_valid_out,
	input wire rd_ready_in,
	output wire [WIDTH-1:0] rd_data_out
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire do_wr;
	wire do_rd;

	// Full and empty come from the occupancy count, so neither can lie.
	assign wr_ready_out = (count != DEPTH[AW:0]);
	assign rd_valid_out = (count != {(AW+1){1'b0}});
	assign rd_data_out = mem[rd_ptr];
	assign do_wr = wr_valid_in & wr_ready_out;
	assign do_rd = rd_valid_out & rd_ready_in;

	// Pointer and count update; flush empties the queue at a command start.
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else if (ce_in) begin
			if (flush_in) begin
				wr_ptr <= {AW{1'b0}};
				rd_ptr <= {AW{1'b0}};
				count <= {(AW+1){1'b0}};
			end else begin
				if (do_wr)
					wr_ptr <= wr_ptr + 1'b1;
				if (do_rd)
					rd_ptr <= rd_ptr + 1'b1;
				if (do_wr & ~do_rd)
					count <= count + 1'b1;
				else if (do_rd & ~do_wr)
					count <= count - 1'b1;
			end
		end
	end

	// Storage needs no reset; nothing reads a slot before it is written.
	always @(posedge core_clk_in) begin
		if (ce_in & do_wr & ~flush_in)
			mem[wr_ptr] <= wr_data_in;
	end

endmodule

// >>> tb/fpes_seq_props.sv
// Concurrent checks on the sequencer's status, array pulses and busy timing.
// Assumes it is bound to fpes_sequencer; one clock serves every port.
`timescale 1ns/10ps
`include "fpes_regs.vh"

module fpes_seq_props #(
	parameter [31:0] PP_CYCLES = 32'h190,
	parameter [31:0] BP_CYCLES = 32'h12C,
	parameter [31:0] BLKE_CYCLES = 32'h32,
	parameter [31:0] CHPE_CYCLES = 32'h50
) (
	// Clock, reset and watched inputs.
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic write_enable_set_in,
	input wire logic error_clear_in,
	input wire logic array_fail_in,
	// Watched outputs.
	input wire logic array_write_out,
	input wire logic [`FPES_ADDR_W-1:0] array_addr_out,
	input wire logic erase_req_out,
	input wire logic [1:0] erase_size_out,
	input wire logic busy_out,
	input wire logic write_enable_latch_out,
	input wire logic program_erase_error_flag_out
);
	reg [31:0] busy_cnt;
	reg [8:0] wr_cnt;
	reg [2:0] kind;
	reg [23:0] last_addr;
	reg [31:0] exp_len;

	// Length, write count and kind of the running operation.
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			busy_cnt <= 32'h0;
			wr_cnt <= 9'h0;
			kind <= 3'h0;
			last_addr <= 24'h0;
		end else begin
			busy_cnt <= busy_out ? busy_cnt + 32'h1 : 32'h0;
			wr_cnt <= busy_out ? wr_cnt + {8'h0, array_write_out} : 9'h0;
			kind <= erase_req_out ? {1'b1, erase_size_out} : (busy_out ? kind : 3'h0);
			last_addr <= array_write_out ? array_addr_out : last_addr;
		end
	end

	// Expected busy length; a single byte uses the shorter byte time.
	always @* begin
		if (kind[2])
			exp_len = (kind[1:0] == `FPES_SIZE_CHIP) ? CHPE_CYCLES : BLKE_CYCLES;
		else
			exp_len = (wr_cnt == 9'h1) ? BP_CYCLES : PP_CYCLES;
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_erase_start;
		erase_req_out && !write_enable_latch_out;
	endsequence
	sequence s_prog_start;
		##[0:257] array_write_out;
	endsequence

	AST_WRITE_IN_BUSY: assert property (array_write_out |-> busy_out)
		else $error("array write outside busy");
	AST_BUSY_CAUSE: assert property ($rose(busy_out) |-> s_erase_start or s_prog_start)
		else $error("busy without erase or write");
	AST_WEL_CLEAR: assert property ($rose(busy_out) && !$past(write_enable_set_in) |-> !write_enable_latch_out)
		else $error("latch still set in operation");
	AST_ERASE_PULSE: assert property (erase_req_out |=> !erase_req_out && busy_out)
		else $error("erase request not one cycle");
	AST_ERASE_MASK: assert property (erase_req_out |-> (erase_size_out == `FPES_SIZE_4K) ? array_addr_out[11:0] == 12'h0 : (erase_size_out == `FPES_SIZE_32K) ? array_addr_out[14:0] == 15'h0 : (erase_size_out == `FPES_SIZE_64K) ? array_addr_out[15:0] == 16'h0 : array_addr_out == 24'h0)
		else $error("erase address low bits kept");
	AST_BUSY_LEN: assert property ($fell(busy_out) |-> busy_cnt >= exp_len && busy_cnt <= exp_len + 32'h1)
		else $error("busy length wrong");
	AST_WRITE_ORDER: assert property (array_write_out && wr_cnt != 9'h0 |-> array_addr_out[23:8] == last_addr[23:8] && array_addr_out[7:0] > last_addr[7:0])
		else $error("page writes out of order");
	AST_ERR_SET: assert property (busy_out && array_fail_in |=> program_erase_error_flag_out)
		else $error("error flag not set on failure");
	AST_ERR_STICKY: assert property (program_erase_error_flag_out && !error_clear_in |=> program_erase_error_flag_out)
		else $error("error flag dropped");
endmodule

// >>> tb/fpes_host_model.sv
// Host model of the serial link: frames commands on select, clock and data.
// Assumes the sequencer oversamples pins; the clock is parked low between frames.
`timescale 1ns/10ps

module fpes_host_model (
	// Link pins toward the sequencer.
	output reg cs_n_out,
	output reg sclk_out,
	output reg si_out,
	output reg upper_out
);
	// Idle link: deselected, clock parked low.
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		si_out = 1'b0;
		upper_out = 1'b1;
	end

	// One 64 ns serial clock; data is set up half a period before the rise.
	task clk_pair(input hi, input lo);
		begin
			upper_out = hi;
			si_out = lo;
			#32;
			sclk_out = 1'b1;
			#32;
			sclk_out = 1'b0;
		end
	endtask

	// Opcode, address, dual data, then stray clocks; released lines flip.
	task frame(input [7:0] op, input [23:0] addr, input integer nad, input integer nd,
		input integer ext, input [7:0] d0);
		integer i;
		integer j;
		reg [7:0] b;
		begin
			cs_n_out = 1'b0;
			for (i = 7; i >= 0; i = i - 1)
				clk_pair(~op[i], op[i]);
			for (i = 0; i < 8 * nad; i = i + 1)
				clk_pair(~addr[23 - i], addr[23 - i]);
			for (j = 0; j < nd; j = j + 1) begin
				b = d0 + j[7:0] + {j[9:8], 6'h00};
				for (i = 3; i >= 0; i = i - 1)
					clk_pair(b[2 * i + 1], b[2 * i]);
			end
			for (i = 0; i < ext; i = i + 1)
				clk_pair(~si_out, ~upper_out);
			#32;
			cs_n_out = 1'b1;
			si_out = ~si_out;
			upper_out = ~upper_out;
		end
	endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench of the program/erase sequencer with a host link model.
// Assumes short self-timed counts; array pulses are matched against a queue.
`timescale 1ns/10ps
`include "fpes_regs.vh"
`define CHK(got, want) begin \
	comparisons = comparisons + 1; \
	if ((got) !== (want)) begin \
		miscompares = miscompares + 1; \
		$display("BAD t=%0t got=%h want=%h", $time, got, want); \
	end \
end

module tb;
	localparam [159:0] ABORTS = {16'h5240, 16'h5AC0, 16'hA2E3, 16'hC702, 16'h20CC,
		16'hD8C2, 16'hA2E1, 16'hA2C0, 16'hA280, 16'hA2E4};
	reg core_clk_in = 1'b0;
	reg rst_in = 1'b1;
	reg wen_set = 1'b0;
	reg err_clr = 1'b0;
	reg fail = 1'b0;
	reg [31:0] prot = 32'h0;
	reg [31:0] lock = 32'h0;
	wire cs_n, sclk, si, up, aw, er, busy, write_enable_latch, eflag;
	wire [23:0] aa;
	wire [7:0] ad;
	wire [1:0] es;
	integer miscompares = 0;
	integer comparisons = 0;
	integer cyc = 0;
	integer k;
	reg [23:0] a;
	reg [7:0] d0;
	reg [15:0] code;
	reg [31:0] seed_val;
	reg busy_seen = 1'b0;
	reg [34:0] exp_q[$];
	reg [34:0] want;

	always #2 core_clk_in = ~core_clk_in;

	fpes_sequencer #(.PP_CYCLES(32'd400), .BP_CYCLES(32'd300), .BLKE_CYCLES(32'd50),
		.CHPE_CYCLES(32'd80)) uut (.core_clk_in(core_clk_in), .rst_in(rst_in),
		.ce_in(1'b1), .chip_select_n_in(cs_n), .serial_clk_in(sclk), .serial_data_in(si),
		.dual_upper_data_pin_in(up), .write_enable_set_in(wen_set), .error_clear_in(err_clr),
		.sector_protect_in(prot), .sector_lock_in(lock), .array_fail_in(fail),
		.array_write_out(aw), .array_addr_out(aa), .array_data_out(ad), .erase_req_out(er),
		.erase_size_out(es), .busy_out(busy), .write_enable_latch_out(write_enable_latch),
		.program_erase_error_flag_out(eflag));
	fpes_host_model host (.cs_n_out(cs_n), .sclk_out(sclk), .si_out(si), .upper_out(up));

	// Each array pulse takes the oldest expected note; an empty queue never matches.
	always @(posedge core_clk_in) begin
		if (busy === 1'b1)
			busy_seen <= 1'b1;
		if (aw === 1'b1 || er === 1'b1) begin
			want = (exp_q.size() > 0) ? exp_q.pop_front() : {35{1'bx}};
			if (aw === 1'b1)
				`CHK({1'b1, 2'h0, aa, ad}, want)
			else
				`CHK({1'b0, es, aa, 8'h00}, want)
		end
	end

	// Cycle ceiling guards against a hung wait.
	always @(posedge core_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			miscompares = miscompares + 1;
			end_of_test;
		end
	end

	// One-cycle strobe: 0 sets the latch, 1 clears the error flag, 2 reports a failure.
	// Driven directly, because a task argument would only reach the pin on return.
	task pulse(input integer sel);
		begin
			@(posedge core_clk_in);
			#1;
			if (sel == 0) begin
				wen_set = 1'b1;
			end else if (sel == 1) begin
				err_clr = 1'b1;
			end else begin
				fail = 1'b1;
			end
			@(posedge core_clk_in);
			#1;
			wen_set = 1'b0;
			err_clr = 1'b0;
			fail = 1'b0;
		end
	endtask

	// Notes the page writes: the newest byte per offset, ascending offsets.
	task push_prog(input [23:0] ad_in, input integer n, input [7:0] b0);
		integer i;
		integer j;
		begin
			for (i = 0; i < 256; i = i + 1) begin
				j = (i - ad_in[7:0]) & 255;
				j = j + 256 * ((n - 1 - j) / 256);
				if (j < n)
					exp_q.push_back({3'h4, ad_in[23:8], i[7:0], b0 + j[7:0] + {j[9:8], 6'h00}});
			end
		end
	endtask

	// Polls busy rather than waiting out the worst case, then checks leftovers.
	task settle(input exp_wel);
		integer w;
		begin
			repeat (12) @(posedge core_clk_in);
			for (w = 0; w < 2000 && busy === 1'b1; w = w + 1)
				@(posedge core_clk_in);
			#1;
			`CHK(exp_q.size(), 0)
			`CHK(write_enable_latch, exp_wel)
		end
	endtask

	task end_of_test;
		begin
			$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
			if (miscompares == 0 && comparisons > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask

	initial begin
		seed_val = $urandom(32'h6196);
		repeat (12) @(posedge core_clk_in);
		#1;
		rst_in = 1'b0;
		repeat (3) @(posedge core_clk_in);
		#1;
		`CHK({aw, er, busy, write_enable_latch, eflag, ad}, 13'h00FF)
		$display("test reset done");
		for (k = 0; k < 3; k = k + 1) begin
			{d0, a} = $urandom;
			if (k == 0)
				a = 24'h0000FE;
			pulse(0);
			push_prog(a, (k == 0) ? 3 : (k == 1) ? 1 : 258, d0);
			host.frame(`FPES_OP_DUAL_PROG, a, 3, (k == 0) ? 3 : (k == 1) ? 1 : 258, 0, d0);
			settle(1'b0);
			$display("test program %0d done", k);
		end
		for (k = 0; k < 5; k = k + 1) begin
			{d0, a} = $urandom;
			code = {8'h0, k[2:0] == 3'h0 ? 8'h20 : k == 1 ? 8'h52 : k == 2 ? 8'hD8 : k == 3 ? 8'h60 : 8'hC7};
			pulse(0);
			exp_q.push_back({1'b0, k[1:0] | {2{k > 2}}, k > 2 ? 24'h0 : a & (k == 0 ?
				24'hFFF000 : k == 1 ? 24'hFF8000 : 24'hFF0000), 8'h00});
			host.frame(code[7:0], a, (k < 3) ? 3 : 0, 0, 8, d0);
			repeat (11) @(posedge core_clk_in);
			// Only the first erase reports a failed location.
			if (k == 0)
				pulse(2);
			settle(1'b0);
			`CHK(eflag, (k == 0))
			pulse(1);
			$display("test erase %0d done", k);
		end
		for (k = 0; k < 10; k = k + 1) begin
			code = ABORTS[16 * k +: 16];
			{d0, a} = $urandom;
			if (code[1:0] != 2'h3)
				pulse(0);
			prot[a[20:16]] = (code[1:0] == 2'h1);
			lock[a[20:16]] = (code[1:0] == 2'h2);
			busy_seen = 1'b0;
			host.frame(code[15:8], a, code[7:6], code[5:4], code[3:2], d0);
			settle(code[15:8] == 8'h5A);
			`CHK(busy_seen, 1'b0)
			prot = 32'h0;
			lock = 32'h0;
			$display("test abort %0d done", k);
		end
		end_of_test;
	end
endmodule

bind fpes_sequencer fpes_seq_props #(.PP_CYCLES(PP_CYCLES), .BP_CYCLES(BP_CYCLES),
	.BLKE_CYCLES(BLKE_CYCLES), .CHPE_CYCLES(CHPE_CYCLES)) u_props (
	.core_clk_in(core_clk_in), .rst_in(rst_in), .write_enable_set_in(write_enable_set_in),
	.error_clear_in(error_clear_in), .array_fail_in(array_fail_in),
	.array_write_out(array_write_out), .array_addr_out(array_addr_out),
	.erase_req_out(erase_req_out), .erase_size_out(erase_size_out), .busy_out(busy_out),
	.write_enable_latch_out(write_enable_latch_out),
	.program_erase_error_flag_out(program_erase_error_flag_out));
